// *** slp_core_port.sv ***
// Core end of the user stream port: takes user beats toward the lanes
// and presents lane data to user logic.
// Assumes the lane logic shares the user clock and never stalls receive.
`timescale 1ns/100ps
module slp_core_port
  import slp_pkg::*;
#(
  parameter slp_dir_t DIR     = SLP_DUPLEX,
  parameter bit       FRAMING = 1'b1
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // User side
  slp_user_if.core                   port_if,
  // Lane side transmit
  output logic      [SLP_DATA_W-1:0] lane_tx_data,
  output logic                       lane_tx_valid,
  output logic                       lane_tx_sep,
  output logic      [SLP_CNT_W-1:0]  lane_tx_count,
  output logic                       lane_tx_keep_err,
  output logic                       lane_tx_in_frame,
  input  wire logic                  lane_tx_hold,
  // Lane side receive
  input  wire logic [SLP_DATA_W-1:0] lane_rx_data,
  input  wire logic                  lane_rx_valid,
  input  wire logic                  lane_rx_last,
  input  wire logic [SLP_CNT_W-1:0]  lane_rx_count,
  output logic                       lane_rx_in_frame
);

  localparam bit TX_ON = (DIR != SLP_RX_ONLY);
  localparam bit RX_ON = (DIR != SLP_TX_ONLY);

  slp_tx_state_t         tx_state_reg;
  slp_tx_state_t         tx_state_next;
  logic                  tx_take;
  logic                  tx_end;
  logic [SLP_CNT_W-1:0]  keep_cnt;
  logic [SLP_DATA_W-1:0] lane_tx_data_reg;
  logic                  lane_tx_valid_reg;
  logic                  lane_tx_sep_reg;
  logic [SLP_CNT_W-1:0]  lane_tx_count_reg;
  logic                  lane_tx_keep_err_reg;
  logic                  tx_in_frame_reg;
  logic [SLP_DATA_W-1:0] rx_data_reg;
  logic                  rx_valid_reg;
  logic                  rx_last_reg;
  logic [SLP_KEEP_W-1:0] rx_keep_reg;
  logic                  rx_in_frame_reg;

  slp_keep_count u_slp_keep_count (
    .keep  (port_if.tx_keep),
    .count (keep_cnt)
  );

  // ready only while data can move
  assign port_if.tx_ready = TX_ON && !lane_tx_hold &&
                            (tx_state_reg == SLP_TX_DATA);

  // beat taken on ready and valid
  assign tx_take = port_if.tx_ready && port_if.tx_valid;

  assign tx_end = FRAMING && tx_take && port_if.tx_last;

  // Separator takes its own cycle, so ready drops after a frame end
  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      SLP_TX_DATA: begin
        if (tx_end) begin
          tx_state_next = SLP_TX_SEP;
        end
      end
      SLP_TX_SEP: begin
        if (!lane_tx_hold) begin
          tx_state_next = SLP_TX_DATA;
        end
      end
    endcase
  end

  // all state on the user clock
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_state_reg <= SLP_TX_DATA;
    end else begin
      tx_state_reg <= tx_state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lane_tx_data_reg  <= SLP_DATA_RST;
      lane_tx_valid_reg <= 1'b0;
    end else begin
      lane_tx_valid_reg <= tx_take;
      if (tx_take) begin
        lane_tx_data_reg <= port_if.tx_data;
      end
    end
  end

  // keep looked at only on frame end
  always_ff @(posedge clock) begin
    if (rst) begin
      lane_tx_count_reg    <= SLP_CNT_RST;
      lane_tx_keep_err_reg <= 1'b0;
    end else begin
      lane_tx_keep_err_reg <= 1'b0;
      if (tx_take) begin
        lane_tx_count_reg <= tx_end ? keep_cnt : SLP_CNT_FULL;
      end
      // flag a mask with holes or a high start
      if (tx_end) begin
        lane_tx_keep_err_reg <=
          (port_if.tx_keep != slp_keep_from_count(keep_cnt));
      end
    end
  end

  // Separator block carries the final count one cycle after the data
  always_ff @(posedge clock) begin
    if (rst) begin
      lane_tx_sep_reg <= 1'b0;
    end else begin
      lane_tx_sep_reg <= (tx_state_reg == SLP_TX_SEP) && !lane_tx_hold;
    end
  end

  // Frame stays open from first beat until the last beat is taken, ahead of the separator
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_in_frame_reg <= 1'b0;
    end else if (tx_end) begin
      tx_in_frame_reg <= 1'b0;
    end else if (tx_take && FRAMING) begin
      tx_in_frame_reg <= 1'b1;
    end
  end

  assign lane_tx_data     = lane_tx_data_reg;
  assign lane_tx_valid    = lane_tx_valid_reg;
  assign lane_tx_sep      = lane_tx_sep_reg;
  assign lane_tx_count    = lane_tx_count_reg;
  assign lane_tx_keep_err = lane_tx_keep_err_reg;
  assign lane_tx_in_frame = tx_in_frame_reg;

  // every lane beat shown once, no stall possible
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg  <= SLP_DATA_RST;
    end else begin
      rx_valid_reg <= RX_ON && lane_rx_valid;
      if (RX_ON && lane_rx_valid) begin
        rx_data_reg <= lane_rx_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_last_reg <= 1'b0;
      rx_keep_reg <= SLP_KEEP_RST;
    end else begin
      rx_last_reg <= FRAMING && RX_ON && lane_rx_valid && lane_rx_last;
      if (FRAMING && RX_ON && lane_rx_valid && lane_rx_last) begin
        rx_keep_reg <= slp_keep_from_count(lane_rx_count);
      end else if (FRAMING && RX_ON) begin
        rx_keep_reg <= SLP_KEEP_ALL;
      end else begin
        rx_keep_reg <= SLP_KEEP_RST;
      end
    end
  end

  // Receive frame open between first beat and the last one
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_in_frame_reg <= 1'b0;
    end else if (FRAMING && RX_ON && lane_rx_valid) begin
      rx_in_frame_reg <= !lane_rx_last;
    end
  end

  assign port_if.rx_data  = rx_data_reg;
  assign port_if.rx_valid = rx_valid_reg;
  // unused ports held at zero in streaming builds
  assign port_if.rx_last  = rx_last_reg;
  assign port_if.rx_keep  = rx_keep_reg;
  assign lane_rx_in_frame = rx_in_frame_reg;

endmodule // slp_core_port

// *** slp_pkg.sv ***
// Shared constants, types and helpers for the user stream port.
// Assumes one user clock and a fixed lane count.
package slp_pkg;

  localparam int SLP_LANES  = 1;
  localparam int SLP_DATA_W = 64 * SLP_LANES;
  localparam int SLP_KEEP_W = 8 * SLP_LANES;
  localparam int SLP_CNT_W  = $clog2(SLP_KEEP_W + 1);

  typedef enum logic [1:0] {
    SLP_DUPLEX  = 2'h0,
    SLP_TX_ONLY = 2'h1,
    SLP_RX_ONLY = 2'h2
  } slp_dir_t;

  typedef enum logic {
    SLP_TX_DATA = 1'h0,
    SLP_TX_SEP  = 1'h1
  } slp_tx_state_t;

  localparam logic [SLP_DATA_W-1:0] SLP_DATA_RST = '0;
  localparam logic [SLP_KEEP_W-1:0] SLP_KEEP_ALL = '1;
  localparam logic [SLP_KEEP_W-1:0] SLP_KEEP_RST = '0;
  localparam logic [SLP_CNT_W-1:0]  SLP_CNT_RST  = '0;
  localparam logic [SLP_CNT_W-1:0]  SLP_CNT_FULL = SLP_CNT_W'(SLP_KEEP_W);

  // Contiguous low-aligned byte mask holding cnt bytes
  function automatic logic [SLP_KEEP_W-1:0] slp_keep_from_count(
    input logic [SLP_CNT_W-1:0] cnt
  );
    logic [SLP_KEEP_W-1:0] m;
    m = '0;
    for (int i = 0; i < SLP_KEEP_W; i++) begin
      m[i] = (SLP_CNT_W'(i) < cnt);
    end
    return m;
  endfunction

endpackage

// *** slp_user_if.sv ***
// Carrier joining the core end and the user end of the stream port.
// Assumes both ends run on the same user clock.
`timescale 1ns/100ps
interface slp_user_if;
  import slp_pkg::*;

  logic [SLP_DATA_W-1:0] tx_data;
  logic [SLP_KEEP_W-1:0] tx_keep;
  logic                  tx_last;
  logic                  tx_valid;
  logic                  tx_ready;
  logic [SLP_DATA_W-1:0] rx_data;
  logic [SLP_KEEP_W-1:0] rx_keep;
  logic                  rx_last;
  logic                  rx_valid;

  modport core (
    input  tx_data,
    input  tx_keep,
    input  tx_last,
    input  tx_valid,
    output tx_ready,
    output rx_data,
    output rx_keep,
    output rx_last,
    output rx_valid
  );

  modport user (
    output tx_data,
    output tx_keep,
    output tx_last,
    output tx_valid,
    input  tx_ready,
    input  rx_data,
    input  rx_keep,
    input  rx_last,
    input  rx_valid
  );
endinterface

// *** slp_keep_count.sv ***
// Counts set bits of a byte mask.
// Assumes the mask is driven from the user clock domain.
`timescale 1ns/100ps
module slp_keep_count
  import slp_pkg::*;
(
  // Mask in
  input  wire logic [SLP_KEEP_W-1:0] keep,
  // Byte count out
  output logic      [SLP_CNT_W-1:0]  count
);

  always_comb begin
    count = '0;
    for (int i = 0; i < SLP_KEEP_W; i++) begin
      count = count + SLP_CNT_W'(keep[i]);
    end
  end

endmodule // slp_keep_count

// *** slp_user_app.sv ***
// User end of the stream port: one-deep source stage toward the core
// and a capture stage for received beats.
// Assumes the application gives a byte count for the final beat.
`timescale 1ns/100ps
module slp_user_app
  import slp_pkg::*;
#(
  parameter slp_dir_t DIR     = SLP_DUPLEX,
  parameter bit       FRAMING = 1'b1
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Core side
  slp_user_if.user                   port_if,
  // Application transmit
  input  wire logic [SLP_DATA_W-1:0] app_tx_data,
  input  wire logic [SLP_CNT_W-1:0]  app_tx_bytes,
  input  wire logic                  app_tx_last,
  input  wire logic                  app_tx_valid,
  output logic                       app_tx_ready,
  // Application receive
  output logic      [SLP_DATA_W-1:0] app_rx_data,
  output logic      [SLP_KEEP_W-1:0] app_rx_keep,
  output logic                       app_rx_last,
  output logic                       app_rx_valid
);

  localparam bit TX_ON = (DIR != SLP_RX_ONLY);
  localparam bit RX_ON = (DIR != SLP_TX_ONLY);

  logic                  hold_valid_reg;
  logic [SLP_DATA_W-1:0] hold_data_reg;
  logic [SLP_KEEP_W-1:0] hold_keep_reg;
  logic                  hold_last_reg;
  logic                  load;
  logic [SLP_DATA_W-1:0] rx_data_reg;
  logic [SLP_KEEP_W-1:0] rx_keep_reg;
  logic                  rx_last_reg;
  logic                  rx_valid_reg;

  // Stage frees when the core takes its beat
  assign app_tx_ready = TX_ON && (!hold_valid_reg || port_if.tx_ready);
  assign load         = app_tx_valid && app_tx_ready;

  // valid only while a beat is held
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_valid_reg <= 1'b0;
    end else if (load) begin
      hold_valid_reg <= 1'b1;
    end else if (port_if.tx_ready) begin
      hold_valid_reg <= 1'b0;
    end
  end

  // last beat with a contiguous mask
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_data_reg <= SLP_DATA_RST;
      hold_keep_reg <= SLP_KEEP_RST;
      hold_last_reg <= 1'b0;
    end else if (load) begin
      hold_data_reg <= app_tx_data;
      hold_last_reg <= FRAMING && app_tx_last;
      hold_keep_reg <= (FRAMING && app_tx_last) ?
                       slp_keep_from_count(app_tx_bytes) : SLP_KEEP_ALL;
    end
  end

  assign port_if.tx_valid = TX_ON && hold_valid_reg;
  assign port_if.tx_data  = hold_data_reg;
  assign port_if.tx_keep  = hold_keep_reg;
  assign port_if.tx_last  = hold_last_reg;

  // every valid receive beat is captured
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_valid_reg <= 1'b0;
      rx_last_reg  <= 1'b0;
      rx_data_reg  <= SLP_DATA_RST;
      rx_keep_reg  <= SLP_KEEP_RST;
    end else begin
      rx_valid_reg <= RX_ON && port_if.rx_valid;
      rx_last_reg  <= RX_ON && port_if.rx_valid && port_if.rx_last;
      if (RX_ON && port_if.rx_valid) begin
        rx_data_reg <= port_if.rx_data;
        rx_keep_reg <= port_if.rx_keep;
      end
    end
  end

  assign app_rx_data  = rx_data_reg;
  assign app_rx_keep  = rx_keep_reg;
  assign app_rx_last  = rx_last_reg;
  assign app_rx_valid = rx_valid_reg;

endmodule // slp_user_app

// *** slp_user_asserts.sv ***
// Checker on the carrier signals between core end and user end.
// Assumes one user clock and a synchronous active-high reset.
`timescale 1ns/100ps
module slp_user_asserts
  import slp_pkg::*;
(
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  rst,
  // Carrier signals
  input wire logic [SLP_DATA_W-1:0] tx_data,
  input wire logic [SLP_KEEP_W-1:0] tx_keep,
  input wire logic                  tx_last,
  input wire logic                  tx_valid,
  input wire logic                  tx_ready,
  input wire logic [SLP_KEEP_W-1:0] rx_keep,
  input wire logic                  rx_last,
  input wire logic                  rx_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_reset_idle: assert property ($fell(rst) |-> !tx_valid && !rx_valid)
    else $error("valid high just after reset");
  chk_tx_valid_hold: assert property (tx_valid && !tx_ready |=> tx_valid)
    else $error("tx valid dropped before ready");
  chk_tx_data_hold: assert property (tx_valid && !tx_ready
    |=> $stable(tx_data) && $stable(tx_last))
    else $error("tx beat changed while waiting");
  chk_tx_sep_gap: assert property (tx_valid && tx_ready && tx_last
    |=> !tx_ready)
    else $error("tx ready high in separator cycle");
  chk_tx_keep_packed: assert property (tx_valid && tx_last
    |-> tx_keep != '0 && (tx_keep & (tx_keep + 1'b1)) == '0)
    else $error("tx keep not packed from low byte");
  chk_rx_keep_full: assert property (rx_valid && !rx_last
    |-> rx_keep == SLP_KEEP_ALL)
    else $error("rx keep not full on inner beat");
  chk_rx_keep_packed: assert property (rx_valid && rx_last
    |-> rx_keep != '0 && (rx_keep & (rx_keep + 1'b1)) == '0)
    else $error("rx keep not packed on last beat");
  chk_rx_last_valid: assert property (rx_last |-> rx_valid)
    else $error("rx last without rx valid");
endmodule // slp_user_asserts

// *** slp_core_port_tb.sv ***
// Testbench joining core end and user end over the carrier.
// Assumes one lane, 100 MHz clock; the main pair is a duplex framing
// build, two side pairs cover streaming and simplex builds.
`timescale 1ns/100ps
module slp_core_port_tb;
  import slp_pkg::*;
  logic                  clock, rst, lane_tx_hold;
  logic [SLP_DATA_W-1:0] app_tx_data, lane_rx_data, app_rx_data, lane_tx_data;
  logic [SLP_CNT_W-1:0]  app_tx_bytes, lane_rx_count, lane_tx_count;
  logic [SLP_KEEP_W-1:0] app_rx_keep;
  logic                  app_tx_last, app_tx_valid, app_tx_ready;
  logic                  lane_rx_valid, lane_rx_last, lane_tx_valid;
  logic                  app_rx_last, app_rx_valid, lane_tx_sep;
  logic [79:0]           txq[$], rxq[$];
  int                    bad_count, num_checks, sep_seen, cyc, hits;
  logic [SLP_CNT_W-1:0]  s_lane_tx_count;
  logic                  s_lane_tx_valid, s_lane_tx_sep, s_app_rx_valid;
  logic                  r_lane_tx_valid, r_app_tx_ready;
  logic                  lane_tx_keep_err, lane_tx_in_frame;
  logic                  lane_rx_in_frame;

  slp_user_if u_if();
  slp_core_port u_slp_core_port (.clock(clock), .rst(rst), .port_if(u_if),
    .lane_tx_data(lane_tx_data), .lane_tx_valid(lane_tx_valid),
    .lane_tx_sep(lane_tx_sep), .lane_tx_count(lane_tx_count),
    .lane_tx_keep_err(lane_tx_keep_err),
    .lane_tx_in_frame(lane_tx_in_frame), .lane_tx_hold(lane_tx_hold),
    .lane_rx_data(lane_rx_data), .lane_rx_valid(lane_rx_valid),
    .lane_rx_last(lane_rx_last), .lane_rx_count(lane_rx_count),
    .lane_rx_in_frame(lane_rx_in_frame));
  slp_user_app u_slp_user_app (.clock(clock), .rst(rst), .port_if(u_if),
    .app_tx_data(app_tx_data), .app_tx_bytes(app_tx_bytes),
    .app_tx_last(app_tx_last), .app_tx_valid(app_tx_valid),
    .app_tx_ready(app_tx_ready), .app_rx_data(app_rx_data),
    .app_rx_keep(app_rx_keep), .app_rx_last(app_rx_last),
    .app_rx_valid(app_rx_valid));

  // Side pairs share the stimulus; only their dead or fixed ports are judged
  slp_user_if u_if_s();
  slp_user_if u_if_r();
  slp_core_port #(.DIR(SLP_TX_ONLY), .FRAMING(1'b0)) u_slp_core_port_s (
    .clock(clock), .rst(rst), .port_if(u_if_s),
    .lane_tx_data(), .lane_tx_valid(s_lane_tx_valid),
    .lane_tx_sep(s_lane_tx_sep), .lane_tx_count(s_lane_tx_count),
    .lane_tx_keep_err(), .lane_tx_in_frame(), .lane_tx_hold(lane_tx_hold),
    .lane_rx_data(lane_rx_data), .lane_rx_valid(lane_rx_valid),
    .lane_rx_last(lane_rx_last), .lane_rx_count(lane_rx_count),
    .lane_rx_in_frame());
  slp_user_app #(.DIR(SLP_TX_ONLY), .FRAMING(1'b0)) u_slp_user_app_s (
    .clock(clock), .rst(rst), .port_if(u_if_s),
    .app_tx_data(app_tx_data), .app_tx_bytes(app_tx_bytes),
    .app_tx_last(app_tx_last), .app_tx_valid(app_tx_valid),
    .app_tx_ready(), .app_rx_data(), .app_rx_keep(), .app_rx_last(),
    .app_rx_valid(s_app_rx_valid));
  slp_core_port #(.DIR(SLP_RX_ONLY), .FRAMING(1'b1)) u_slp_core_port_r (
    .clock(clock), .rst(rst), .port_if(u_if_r),
    .lane_tx_data(), .lane_tx_valid(r_lane_tx_valid),
    .lane_tx_sep(), .lane_tx_count(),
    .lane_tx_keep_err(), .lane_tx_in_frame(), .lane_tx_hold(lane_tx_hold),
    .lane_rx_data(lane_rx_data), .lane_rx_valid(lane_rx_valid),
    .lane_rx_last(lane_rx_last), .lane_rx_count(lane_rx_count),
    .lane_rx_in_frame());
  slp_user_app #(.DIR(SLP_RX_ONLY), .FRAMING(1'b1)) u_slp_user_app_r (
    .clock(clock), .rst(rst), .port_if(u_if_r),
    .app_tx_data(app_tx_data), .app_tx_bytes(app_tx_bytes),
    .app_tx_last(app_tx_last), .app_tx_valid(app_tx_valid),
    .app_tx_ready(r_app_tx_ready), .app_rx_data(), .app_rx_keep(),
    .app_rx_last(), .app_rx_valid());
  slp_user_asserts u_slp_user_asserts (.clock(clock), .rst(rst),
    .tx_data(u_if.tx_data), .tx_keep(u_if.tx_keep), .tx_last(u_if.tx_last),
    .tx_valid(u_if.tx_valid), .tx_ready(u_if.tx_ready),
    .rx_keep(u_if.rx_keep), .rx_last(u_if.rx_last),
    .rx_valid(u_if.rx_valid));

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Beat stays offered until the user end takes it; caller ends the run
  task automatic tx_beat(input logic [63:0] d, input logic [3:0] n,
                         input logic l);
    app_tx_data <= d;
    app_tx_bytes <= n;
    app_tx_last <= l;
    app_tx_valid <= 1'b1;
    txq.push_back({d, l ? n : 4'h8});
    @(posedge clock);
    while (app_tx_ready !== 1'b1) @(posedge clock);
  endtask

  task automatic rx_beat(input logic [63:0] d, input logic [3:0] n,
                         input logic l);
    lane_rx_data <= d;
    lane_rx_count <= n;
    lane_rx_last <= l;
    lane_rx_valid <= 1'b1;
    rxq.push_back({d, l ? 8'hff >> (4'h8 - n) : 8'hff, l});
    @(posedge clock);
  endtask

  // Idle drives, then a fixed 40-cycle wait before checking both pipelines are empty
  task automatic drain(input string name);
    app_tx_valid <= 1'b0;
    app_tx_data <= ~app_tx_data;
    lane_rx_valid <= 1'b0;
    lane_rx_data <= ~lane_rx_data;
    repeat (40) @(posedge clock);
    chk(txq.size() + rxq.size(), 0);
    chk({lane_tx_in_frame, lane_rx_in_frame}, 2'b00);
    $display("test %s done", name);
  endtask

  task automatic t_tx_frame;
    hits = sep_seen;
    for (int i = 0; i < 3; i++)
      tx_beat(64'h0706050403020100 + i, 4'h5, i == 2);
    chk(lane_tx_in_frame, 1'b1);
    drain("tx_frame");
    chk(sep_seen - hits, 1);
  endtask

  task automatic t_tx_hold;
    lane_tx_hold <= 1'b1;
    tx_beat(64'h1122334455667788, 4'h8, 1'b0);
    app_tx_valid <= 1'b0;
    hits = 0;
    repeat (6) begin
      @(posedge clock);
      if (lane_tx_valid === 1'b1) hits++;
    end
    chk(hits, 0);
    lane_tx_hold <= 1'b0;
    tx_beat(64'h99aabbccddeeff00, 4'h1, 1'b1);
    drain("tx_hold");
  endtask

  task automatic t_tx_sizes;
    hits = sep_seen;
    for (int n = 1; n <= 8; n++)
      tx_beat(64'hf0e1d2c3b4a59687 ^ n, 4'(n), 1'b1);
    drain("tx_sizes");
    chk(sep_seen - hits, 8);
  endtask

  task automatic t_rx_frames;
    for (int i = 0; i < 3; i++) begin
      rx_beat(64'h0123456789abcdef + i, 4'h3, i == 2);
      if (i == 1) chk(lane_rx_in_frame, 1'b1);
    end
    for (int n = 1; n <= 8; n++)
      rx_beat(64'hfedcba9876543210 ^ n, 4'(n), 1'b1);
    drain("rx_frames");
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  always @(posedge clock) begin
    if (lane_tx_sep === 1'b1) sep_seen++;
    if (rst === 1'b0) begin
      chk(lane_tx_keep_err, 1'b0);
      chk(s_lane_tx_sep, 1'b0);
      chk(s_app_rx_valid, 1'b0);
      chk(r_app_tx_ready, 1'b0);
      chk(r_lane_tx_valid, 1'b0);
      if (s_lane_tx_valid === 1'b1)
        chk(s_lane_tx_count, SLP_CNT_FULL);
    end
    if (lane_tx_valid === 1'b1)
      chk({lane_tx_data, lane_tx_count}, txq.pop_front());
    if (app_rx_valid === 1'b1)
      chk({app_rx_data, app_rx_keep, app_rx_last}, rxq.pop_front());
  end

  initial begin
    rst = 1'b1;
    lane_tx_hold = 1'b0;
    app_tx_data = '0;
    app_tx_bytes = '0;
    app_tx_last = 1'b0;
    app_tx_valid = 1'b0;
    lane_rx_data = '0;
    lane_rx_count = '0;
    lane_rx_last = 1'b0;
    lane_rx_valid = 1'b0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_tx_frame();
    t_tx_hold();
    t_tx_sizes();
    t_rx_frames();
    tally_and_finish();
  end
endmodule // slp_core_port_tb
